// ---- tb/ltec_chk.sv ----
// Purpose: port checker for the line trigger controller
// Assumes: triggers at least 50 cycles apart, modes change under reset
// Notes:   bound to the top module
`timescale 1ns/100ps
module ltec_chk (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire ltec_pkg::ltec_req_t     req,
  input wire logic [ltec_pkg::DW-1:0] rdata,
  input wire logic                    cc1_trig,
  input wire logic                    ext_trig,
  input wire logic                    line_trig,
  input wire logic                    expose,
  input wire logic                    readout
);
  logic [7:0] gap_r;
  logic [7:0] run_r;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // cycles since the last line start, and length of the current exposure
  always_ff @(posedge clk) begin
    if (srst) gap_r <= 8'hff;
    else if (line_trig) gap_r <= 8'h00;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (srst || !expose) run_r <= 8'h00;
    else if (run_r != 8'hff) run_r <= run_r + 8'h01;
  end
  property p_rd_zero;
    !$past(req.rd) |-> rdata == '0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
  property p_lt_one;
    line_trig |=> !line_trig;
  endproperty
  a_lt_one: assert property (p_lt_one) else $error("line start not one cycle");
  property p_ro_one;
    readout |=> !readout;
  endproperty
  a_ro_one: assert property (p_ro_one) else $error("readout not one cycle");
  property p_lt_exp;
    line_trig |-> expose;
  endproperty
  a_lt_exp: assert property (p_lt_exp) else $error("line start without exposure");
  // a fall caused by reset carries no readout
  property p_fall_ro;
    $fell(expose) && !$past(srst) |-> ##[0:2] readout;
  endproperty
  a_fall_ro: assert property (p_fall_ro) else $error("no readout after exposure");
  property p_ro_src;
    readout |-> $past(expose) || $past(expose, 2);
  endproperty
  a_ro_src: assert property (p_ro_src) else $error("readout without exposure");
  property p_gap;
    line_trig |-> gap_r >= 8'd49;
  endproperty
  a_gap: assert property (p_gap) else $error("line starts too close");
  // run_r lags the window by one, so at the fall it holds the full count: 24 means at least 24 cycles high
  property p_exp_min;
    $fell(expose) && !$past(srst) |-> run_r >= 8'd24;
  endproperty
  a_exp_min: assert property (p_exp_min) else $error("exposure too short");
endmodule
bind ltec_top ltec_chk chk_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
  .cc1_trig(cc1_trig), .ext_trig(ext_trig), .line_trig(line_trig), .expose(expose),
  .readout(readout));

// ---- tb/ltec_tb_top.sv ----
// Purpose: self-checking bench for the line trigger controller
// Assumes: 25 MHz clock, register port with one-cycle read latency
// Notes:   each scenario except the longer-period rerun starts from a fresh reset
`timescale 1ns/100ps
module ltec_tb_top;
  logic                clk;
  logic                srst;
  ltec_pkg::ltec_req_t req;
  logic [31:0]         rdata;
  logic                cc1_trig;
  logic                ext_trig;
  logic                line_trig;
  logic                expose;
  logic                readout;
  int                  errors;
  int                  num_checks;
  int                  cyc;
  logic [31:0]         d;
  int                  w;
  int                  p;
  int                  r;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'h0, 32'h9c4, 32'h4e2, 32'h64, 32'h0, 32'h0, 32'hffffff, 32'h0};
  ltec_top dut_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .cc1_trig(cc1_trig),
    .ext_trig(ext_trig), .line_trig(line_trig), .expose(expose), .readout(readout));
  ltec_trig_src trg_u (.clk(clk), .cc1_trig(cc1_trig), .ext_trig(ext_trig));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
    num_checks++;
    if (((g + tol >= e) && (g <= e + tol)) !== 1'b1) begin
      errors++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 v = rdata;
  endtask
  task automatic setup(input logic [6:0] c, input logic [23:0] lp, input logic [23:0] ex);
    @(posedge clk);
    srst <= 1'b1;
    trg_u.idle(c[5]);
    srst <= 1'b0;
    wr_reg(ltec_pkg::A_LPER, {8'h00, lp});
    wr_reg(ltec_pkg::A_EXPT, {8'h00, ex});
    wr_reg(ltec_pkg::A_RATIO, 32'hc8);
    wr_reg(ltec_pkg::A_CTRL, {25'h0, c});
  endtask
  // one line: exposure cycles, period to the next line start, readouts
  task automatic meas(output int w, output int p, output int r);
    int n;
    n = 0;
    w = 0;
    p = 0;
    r = 0;
    while (line_trig !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    do begin
      @(posedge clk);
      #1 p++;
      if (expose === 1'b1) w++;
      if (readout === 1'b1) r++;
    end while (line_trig !== 1'b1 && p < 2000);
  endtask
  task automatic quiet(output int c);
    c = 0;
    repeat (300) begin
      @(posedge clk);
      #1 if (line_trig === 1'b1) c++;
    end
  endtask
  initial begin
    req = '0;
    srst = 1'b1;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_reg(ra[i], d);
      chk(d, rv[i], 0);
    end
    wr_reg(ltec_pkg::A_LPER, 32'ha);
    rd_reg(ltec_pkg::A_LPER, d);
    chk(d, 32'h32, 0);
    foreach (rv[i]) begin
      if (i < 3) begin
        wr_reg(ltec_pkg::A_RATIO, i == 0 ? 32'h1 : i == 1 ? 32'h4e20 : 32'h3e7);
        rd_reg(ltec_pkg::A_RATIO, d);
        chk(d, i == 0 ? 32'h2 : i == 1 ? 32'h2710 : 32'h3e7, 0);
      end
    end
    setup(7'h40, 24'd100, 24'd60);
    meas(w, p, r);
    chk(w, 60, 0);
    chk(p, 100, 0);
    chk(r, 1, 0);
    rd_reg(ltec_pkg::A_LCNT, d);
    chk(d, 1, 0);
    wr_reg(ltec_pkg::A_LCNT, 32'h0);
    rd_reg(ltec_pkg::A_LCNT, d);
    chk(d, 0, 0);
    // spare mode code runs free as well
    setup(7'h43, 24'd100, 24'd10);
    meas(w, p, r);
    chk(w, 50, 0);
    setup(7'h40, 24'd100, 24'd200);
    meas(w, p, r);
    chk(w, 100, 1);
    // a longer period lets the stored exposure through
    wr_reg(ltec_pkg::A_LPER, 32'h12c);
    meas(w, p, r);
    chk(w, 200, 0);
    chk(p, 300, 0);
    // second pass: connector, active low, spare style code
    for (int k = 0; k < 2; k++) begin
      setup(k ? 7'h7d : 7'h41, 24'd100, 24'd60);
      fork
        trg_u.burst(k, k, 30, 100, 3);
        meas(w, p, r);
      join
      chk(w, 60, 0);
      chk(p, 130, 0);
      chk(r, 1, 0);
    end
    setup(7'h45, 24'd100, 24'd60);
    fork
      trg_u.burst(0, 0, 70, 80, 3);
      meas(w, p, r);
    join
    chk(w, 70, 2);
    chk(r, 1, 0);
    setup(7'h49, 24'd100, 24'd60);
    fork
      trg_u.burst(0, 0, 30, 120, 4);
      meas(w, p, r);
    join
    chk(w, 150, 1);
    chk(p, 150, 0);
    // pass 0: pulse one cycle too short; pass 1: pulses on the unselected input
    for (int k = 0; k < 2; k++) begin
      setup(7'h41, 24'd100, 24'd60);
      fork
        trg_u.burst(k, 0, k ? 30 : 24, 100, 2);
        quiet(w);
      join
      chk(w, 0, 0);
    end
    setup(7'h46, 24'd100, 24'd60);
    fork
      trg_u.burst(0, 0, 30, 170, 8);
      begin
        repeat (800) @(posedge clk);
        rd_reg(ltec_pkg::A_CPER, d);
        chk(d, 100, 0);
        meas(w, p, r);
        chk(w, 60, 0);
        chk(p, 100, 0);
      end
    join
    end_sim();
  end
endmodule

// ---- tb/ltec_trig_src.sv ----
// Purpose: far-side trigger source feeding the connector and control line
// Assumes: levels change just after a rising edge
// Notes:   the line not in use rests at the inactive level
`timescale 1ns/100ps
module ltec_trig_src (
  input  wire logic clk,
  output logic      cc1_trig,
  output logic      ext_trig
);
  initial begin
    cc1_trig = 1'b0;
    ext_trig = 1'b0;
  end
  task automatic idle(input logic pol);
    @(posedge clk);
    cc1_trig <= pol;
    ext_trig <= pol;
  endtask
  // short hi values break the minimum width only when a scenario asks
  task automatic burst(input logic src, input logic pol, input int hi, input int lo, input int n);
    repeat (n) begin
      @(posedge clk);
      if (src) ext_trig <= ~pol;
      else cc1_trig <= ~pol;
      repeat (hi) @(posedge clk);
      if (src) ext_trig <= pol;
      else cc1_trig <= pol;
      repeat (lo - 1) @(posedge clk);
    end
  endtask
endmodule

// ---- verilog/ltec_pkg.sv ----
// Purpose: shared constants and types for the line trigger and exposure controller
// Assumes: 25 MHz clock, 32-bit register data, plain strobe register port
// Notes:   times are in microseconds, counts in clock cycles derived from them
package ltec_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned US_PER_S     = 1_000_000;
  localparam int unsigned CW           = 24;
  localparam int unsigned DW           = 32;
  localparam int unsigned AW           = 8;

  // least times, rounded up to whole cycles
  localparam int unsigned EXP_MIN_US   = 2;
  localparam int unsigned EXP_MIN_CYC  = (EXP_MIN_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
  localparam int unsigned TRIG_MIN_US  = 1;
  localparam int unsigned TRIG_MIN_CYC = (TRIG_MIN_US * CLK_HZ + US_PER_S - 1) / US_PER_S;

  // converter ratio held in hundredths
  localparam logic [13:0] RATIO_MIN    = 14'h0002;
  localparam logic [13:0] RATIO_MAX    = 14'h2710;
  localparam logic [6:0]  RATIO_UNIT   = 7'h64;

  localparam logic [AW-1:0] A_CTRL     = 8'h00;
  localparam logic [AW-1:0] A_LPER     = 8'h04;
  localparam logic [AW-1:0] A_EXPT     = 8'h08;
  localparam logic [AW-1:0] A_RATIO    = 8'h0c;
  localparam logic [AW-1:0] A_STAT     = 8'h10;
  localparam logic [AW-1:0] A_LCNT     = 8'h14;
  localparam logic [AW-1:0] A_CPER     = 8'h18;

  localparam logic [6:0]    CTRL_RST   = 7'h00;
  localparam logic [CW-1:0] LPER_RST   = 24'h0009c4;
  localparam logic [CW-1:0] EXPT_RST   = 24'h0004e2;
  localparam logic [13:0]   RATIO_RST  = 14'h0064;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_EXT  = 2'b01,
    MODE_CONV = 2'b10
  } ltec_mode_t;

  typedef enum logic [1:0] {
    EXP_PROG  = 2'b00,
    EXP_PULSE = 2'b01,
    EXP_EDGE  = 2'b10
  } ltec_style_t;

  // control register layout, bit 0 upward: mode, style, src, pol, en
  typedef struct packed {
    logic        en;
    logic        pol;
    logic        src;
    ltec_style_t style;
    ltec_mode_t  mode;
  } ltec_ctrl_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ltec_req_t;

endpackage

// ---- verilog/ltec_top.sv ----
// Purpose: line trigger and exposure window generator for a line-scan sensor
// Assumes: one clock, synchronous reset, registers on a plain strobe port
// Notes:   line period and exposure are in clock cycles; ratio in hundredths
`timescale 1ns/100ps
module ltec_top #(
  parameter int unsigned CW = ltec_pkg::CW
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire ltec_pkg::ltec_req_t       req,
  output logic [ltec_pkg::DW-1:0]        rdata,
  input  wire logic                      cc1_trig,
  input  wire logic                      ext_trig,
  output logic                           line_trig,
  output logic                           expose,
  output logic                           readout
);

  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v,
                                          input logic [CW-1:0] lo,
                                          input logic [CW-1:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  localparam logic [CW-1:0] EXP_MIN = CW'(ltec_pkg::EXP_MIN_CYC);
  localparam logic [CW-1:0] ALL1    = {CW{1'b1}};

  ltec_pkg::ltec_ctrl_t ctrl_r;
  logic [CW-1:0]        lper_r;
  logic [CW-1:0]        expt_r;
  logic [13:0]          ratio_r;
  logic [31:0]          lcnt_r;
  logic [31:0]          rdata_r;

  logic                 trig_lvl;
  logic                 trig_d_r;
  logic [CW-1:0]        meas_cnt_r;
  logic                 seen_r;

  logic                 div_busy_r;
  logic [5:0]           div_cnt_r;
  logic [31:0]          quo_r;
  logic [14:0]          rem_r;
  logic [CW-1:0]        cper_r;
  logic                 cper_vld_r;

  logic [CW-1:0]        pc_r;
  logic [CW-1:0]        ec_r;
  logic                 ec_run_r;
  logic                 armed_r;
  logic                 line_trig_r;
  logic                 expose_r;
  logic                 readout_r;

  // register decode
  wire logic wr_ctrl  = req.wr && req.addr == ltec_pkg::A_CTRL;
  wire logic wr_lper  = req.wr && req.addr == ltec_pkg::A_LPER;
  wire logic wr_expt  = req.wr && req.addr == ltec_pkg::A_EXPT;
  wire logic wr_ratio = req.wr && req.addr == ltec_pkg::A_RATIO;
  wire logic wr_lcnt  = req.wr && req.addr == ltec_pkg::A_LCNT;

  // mode and style actually in force
  wire logic is_free = ctrl_r.mode != ltec_pkg::MODE_EXT && ctrl_r.mode != ltec_pkg::MODE_CONV;
  wire logic is_ext  = ctrl_r.mode == ltec_pkg::MODE_EXT;
  wire logic is_conv = ctrl_r.mode == ltec_pkg::MODE_CONV;
  wire ltec_pkg::ltec_style_t style =
    (is_free || ctrl_r.style == 2'h3) ? ltec_pkg::EXP_PROG :  // spare style code acts as programmed
    (is_conv && ctrl_r.style != ltec_pkg::EXP_EDGE) ? ltec_pkg::EXP_PROG :
    ctrl_r.style;
  wire logic st_prog  = style == ltec_pkg::EXP_PROG;
  wire logic st_pulse = style == ltec_pkg::EXP_PULSE;
  wire logic st_edge  = style == ltec_pkg::EXP_EDGE;

  // trigger edges after filtering and polarity
  wire logic rise = trig_lvl && !trig_d_r;
  wire logic fall = !trig_lvl && trig_d_r;

  // line timing
  wire logic [CW-1:0] per      = is_conv ? cper_r : lper_r;
  wire logic          gen_run  = ctrl_r.en && (is_free || (is_conv && cper_vld_r));
  wire logic          gen_go   = gen_run && pc_r == '0;
  wire logic          line_go  = ctrl_r.en && (is_ext ? rise : gen_go);
  wire logic [CW-1:0] exp_hi   = is_ext ? ALL1 : per;
  wire logic [CW-1:0] exp_eff  = clamp(expt_r, EXP_MIN, exp_hi);
  wire logic          ec_done  = ec_run_r && ec_r == '0;

  // converter divider: period = measured * 100 / ratio
  wire logic [15:0]   div_try  = {rem_r, quo_r[31]} - {2'b00, ratio_r};
  wire logic [31:0]   div_num  = 32'(meas_cnt_r) * 32'(ltec_pkg::RATIO_UNIT);
  wire logic [CW-1:0] quo_sat  = (|quo_r[31:CW]) ? ALL1 : quo_r[CW-1:0];

  // outputs of the next cycle
  wire logic expose_nxt  = ctrl_r.en && ((st_prog && (line_go || (ec_run_r && !ec_done)))
                                         || (st_pulse && is_ext && trig_lvl)
                                         || (st_edge && (armed_r || line_go)));
  wire logic readout_nxt = ctrl_r.en && ((st_prog && ec_done && !line_go)
                                         || (st_pulse && is_ext && fall)
                                         || (st_edge && armed_r && line_go));

  // read mux
  wire logic [31:0] stat_w  = {27'h0, armed_r, div_busy_r, cper_vld_r, trig_lvl, expose_r};
  wire logic [31:0] rd_mux  =
    (req.addr == ltec_pkg::A_CTRL)  ? 32'(ctrl_r)  :
    (req.addr == ltec_pkg::A_LPER)  ? 32'(lper_r)  :
    (req.addr == ltec_pkg::A_EXPT)  ? 32'(expt_r)  :
    (req.addr == ltec_pkg::A_RATIO) ? 32'(ratio_r) :
    (req.addr == ltec_pkg::A_STAT)  ? stat_w       :
    (req.addr == ltec_pkg::A_LCNT)  ? lcnt_r       :
    (req.addr == ltec_pkg::A_CPER)  ? 32'(cper_r)  : 32'h0000_0000;

  ltec_trig_filt #(
    .MINC     (ltec_pkg::TRIG_MIN_CYC)
  ) u_filt (
    .clk      (clk),
    .srst     (srst),
    .cc1_trig (cc1_trig),
    .ext_trig (ext_trig),
    .src      (ctrl_r.src),
    .pol      (ctrl_r.pol),
    .level    (trig_lvl)
  );

  // software registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r  <= ltec_pkg::ltec_ctrl_t'(ltec_pkg::CTRL_RST);
      lper_r  <= ltec_pkg::LPER_RST;
      expt_r  <= ltec_pkg::EXPT_RST;
      ratio_r <= ltec_pkg::RATIO_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ltec_pkg::ltec_ctrl_t'(req.wdata[6:0]);
      end
      if (wr_lper) begin
        lper_r <= clamp(req.wdata[CW-1:0], EXP_MIN, ALL1);
      end
      if (wr_expt) begin
        expt_r <= req.wdata[CW-1:0];
      end
      if (wr_ratio) begin
        ratio_r <= (req.wdata[31:14] != 18'h0) ? ltec_pkg::RATIO_MAX :
                   (req.wdata[13:0] < ltec_pkg::RATIO_MIN) ? ltec_pkg::RATIO_MIN :
                   (req.wdata[13:0] > ltec_pkg::RATIO_MAX) ? ltec_pkg::RATIO_MAX :
                   req.wdata[13:0];
      end
      rdata_r <= req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // line counter, a software clear in the same cycle as a hardware increment leaves it at one
  always_ff @(posedge clk) begin
    if (srst) begin
      lcnt_r <= 32'h0000_0000;
    end else if (readout_nxt) begin
      lcnt_r <= wr_lcnt ? 32'h0000_0001 : lcnt_r + 32'h0000_0001;
    end else if (wr_lcnt) begin
      lcnt_r <= 32'h0000_0000;
    end
  end

  // external period measurement between filtered rising edges
  always_ff @(posedge clk) begin
    if (srst) begin
      trig_d_r   <= 1'b0;
      meas_cnt_r <= '0;
      seen_r     <= 1'b0;
    end else begin
      trig_d_r <= trig_lvl;
      if (rise) begin
        meas_cnt_r <= CW'(1);
        seen_r     <= 1'b1;
      end else if (meas_cnt_r != ALL1) begin
        meas_cnt_r <= meas_cnt_r + CW'(1);
      end
    end
  end

  // serial restoring divider, restarted on every measured period
  always_ff @(posedge clk) begin
    if (srst) begin
      div_busy_r <= 1'b0;
      div_cnt_r  <= 6'h00;
      quo_r      <= 32'h0000_0000;
      rem_r      <= 15'h0000;
      cper_r     <= ALL1;
      cper_vld_r <= 1'b0;
    end else if (!is_conv) begin
      div_busy_r <= 1'b0;
      cper_vld_r <= 1'b0;
    end else if (rise && seen_r) begin
      div_busy_r <= 1'b1;
      div_cnt_r  <= 6'h20;
      quo_r      <= div_num;
      rem_r      <= 15'h0000;
    end else if (div_busy_r && div_cnt_r != 6'h00) begin
      div_cnt_r <= div_cnt_r - 6'h01;
      quo_r     <= {quo_r[30:0], !div_try[15]};
      rem_r     <= div_try[15] ? {rem_r[13:0], quo_r[31]} : div_try[14:0];
    end else if (div_busy_r) begin
      div_busy_r <= 1'b0;
      cper_r     <= clamp(quo_sat, EXP_MIN, ALL1);
      cper_vld_r <= 1'b1;
    end
  end

  // internal line period counter for free-run and converter modes
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_r <= '0;
    end else if (!gen_run) begin
      pc_r <= '0;
    end else if (gen_go) begin
      pc_r <= per - CW'(1);
    end else begin
      pc_r <= pc_r - CW'(1);
    end
  end

  // programmed exposure timer and edge-style arming
  always_ff @(posedge clk) begin
    if (srst) begin
      ec_r     <= '0;
      ec_run_r <= 1'b0;
      armed_r  <= 1'b0;
    end else if (!ctrl_r.en) begin
      ec_run_r <= 1'b0;
      armed_r  <= 1'b0;
    end else begin
      if (st_prog && line_go) begin
        ec_r     <= exp_eff - CW'(1);
        ec_run_r <= 1'b1;
      end else if (ec_done || !st_prog) begin
        ec_run_r <= 1'b0;
      end else if (ec_run_r) begin
        ec_r <= ec_r - CW'(1);
      end
      armed_r <= st_edge && (armed_r || line_go);
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      line_trig_r <= 1'b0;
      expose_r    <= 1'b0;
      readout_r   <= 1'b0;
    end else begin
      line_trig_r <= line_go;
      expose_r    <= expose_nxt;
      readout_r   <= readout_nxt;
    end
  end

  assign rdata     = rdata_r;
  assign line_trig = line_trig_r;
  assign expose    = expose_r;
  assign readout   = readout_r;

endmodule

// ---- verilog/ltec_trig_filt.sv ----
// Purpose: external trigger source select, polarity and short pulse rejection
// Assumes: trigger inputs synchronous to clk
// Notes:   output level follows the input only after it has held for MINC cycles
`timescale 1ns/100ps
module ltec_trig_filt #(
  parameter int unsigned MINC = ltec_pkg::TRIG_MIN_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic cc1_trig,
  input  wire logic ext_trig,
  input  wire logic src,
  input  wire logic pol,
  output logic      level
);

  logic [7:0] cnt_r;
  logic       level_r;
  wire  logic raw;
  wire  logic differs;
  wire  logic settled;

  // active low inputs are inverted before any edge is looked at
  assign raw     = (src ? ext_trig : cc1_trig) ^ pol;
  assign differs = raw != level_r;
  assign settled = cnt_r == 8'(MINC - 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r   <= 8'h00;
      level_r <= 1'b0;
    end else if (differs && settled) begin
      cnt_r   <= 8'h00;
      level_r <= raw;
    end else if (differs) begin
      cnt_r   <= cnt_r + 8'h01;
    end else begin
      cnt_r   <= 8'h00;
    end
  end

  assign level = level_r;

endmodule
